// File: hw/mpac_debounce.sv
// two-flop synchroniser and stable-time debounce per contact input
module mpac_debounce #(
    parameter int N = 2
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic [N-1:0] raw_n,
    output logic      [N-1:0] pressed
);
    import mpac_pkg::*;

    genvar g;
    for (g = 0; g < N; g++) begin : g_bit
        logic       s0_reg;
        logic       s1_reg;
        logic       st_reg;
        logic [3:0] cnt_reg;
        wire        same = (s1_reg == st_reg);
        wire        full = (cnt_reg == 4'(DEB_MS - 1));

        // contacts pull to ground, so a closure reads as pressed
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                s0_reg  <= 1'b0;
                s1_reg  <= 1'b0;
                st_reg  <= 1'b0;
                cnt_reg <= 4'h0;
            end else begin
                s0_reg <= ~raw_n[g];
                s1_reg <= s0_reg;
                if (same) begin
                    cnt_reg <= 4'h0;
                end else if (tick) begin
                    cnt_reg <= full ? 4'h0 : cnt_reg + 4'h1;
                    if (full) st_reg <= s1_reg;      // stable long enough
                end
            end
        end
        assign pressed[g] = st_reg;
    end
endmodule // mpac_debounce

// File: hw/mpac_pkg.sv
// constants, register map and mode encoding of the actuator front end
package mpac_pkg;
    // clock and time base
    localparam int CLK_NS        = 25;
    localparam int TICK_NS       = 1_000_000;          // 1 ms time base
    localparam int TICK_CYC      = TICK_NS / CLK_NS;
    localparam int SETUP_HOLD_S  = 8;                  // both held, seconds
    localparam int SETUP_HOLD_MS = SETUP_HOLD_S * 1000;
    localparam int PRESS_MIN_MS  = 50;                 // shortest closure
    localparam int DEB_MS        = 5;                  // debounce window
    // accept a little early so debounce and tick jitter never lose one
    localparam int PRESS_ACC_MS  = PRESS_MIN_MS - 2 * DEB_MS;
    localparam int FLASH_MS      = 250;                // display blink half

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_CONFIG   = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // field positions
    localparam int CTRL_AUTO_LATCH = 0;
    localparam int CFG_COUNT_LSB   = 0;
    localparam int CFG_OFFSET_LSB  = 8;
    localparam int STAT_POS_LSB    = 0;
    localparam int STAT_MODE_LSB   = 8;
    localparam int STAT_RUN        = 10;
    localparam int STAT_DIR        = 11;
    localparam int STAT_FAULT      = 12;

    // interrupt bits
    localparam int IRQ_STEP  = 0;
    localparam int IRQ_HOME  = 1;
    localparam int IRQ_BCD   = 2;
    localparam int IRQ_DONE  = 3;
    localparam int IRQ_FAULT = 4;
    localparam int IRQ_MODE  = 5;
    localparam int IRQ_W     = 6;

    // reset values and limits
    localparam logic [6:0] COUNT_RST  = 7'h0A;
    localparam logic [6:0] OFFSET_RST = 7'h01;
    localparam logic [6:0] POS_TOP    = 7'h60;         // 96
    localparam logic [6:0] COUNT_MIN  = 7'h02;

    // gray coded along oper -> both -> setup -> leave
    typedef enum logic [1:0] {
        MPAC_OPER  = 2'b00,
        MPAC_BOTH  = 2'b01,
        MPAC_SETUP = 2'b11,
        MPAC_LEAVE = 2'b10
    } mpac_mode_e;
endpackage

// File: hw/mpac_top.sv
// multiposition actuator front end: switches, modes, bcd port, apb regs
//
// Summary of operation
// - power up in operating mode showing position
// - left switch steps, right switch homes
// - brief both-press reverses direction and LEDs
// - both held 8 s enters flashing setup
// - setup: step increments, home decrements count
// - setup: both pressed returns to operating mode
// - display position, count, or fault indication
// - closure of 50 ms gives one step/home
// - bcd position out, bcd request with latch
// - bcd requests only offset to offset+count-1
// - auto latch acts on changed bcd input
module mpac_top #(
    parameter int TICK_CYCLES = mpac_pkg::TICK_CYC,
    parameter int SETUP_TICKS = mpac_pkg::SETUP_HOLD_MS
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        step_in_n,
    input  wire logic        home_in_n,
    input  wire logic        data_latch,
    input  wire logic [7:0]  bcd_in,
    input  wire logic        motor_done,
    input  wire logic        fault_in,
    output logic             motor_run,
    output logic             dir_out,
    output logic             error_out,
    output logic      [7:0]  bcd_out,
    output logic      [7:0]  disp_value,
    output logic             disp_blank,
    output logic             disp_fault,
    output logic             led_dir_fwd,
    output logic             led_dir_rev,
    output logic             irq
);
    import mpac_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    function automatic logic [7:0] to_bcd(input logic [6:0] v);
        return {4'(v / 7'd10), 4'(v % 7'd10)};
    endfunction

    // 1 ms enable; a parameter so simulation can shorten every count
    logic [15:0] div_reg;
    logic        tick_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (div_reg == 16'(TICK_CYCLES - 2)); // wrap adds a cycle
            div_reg  <= tick_reg ? 16'h0000 : div_reg + 16'h0001;
        end
    end

    // contact inputs, manual and external share the same lines
    logic [1:0] pressed;
    mpac_debounce #(.N(2)) u_deb (
        .clk     (pclk),
        .rst_n   (presetn),
        .tick    (tick_reg),
        .raw_n   ({home_in_n, step_in_n}),
        .pressed (pressed)
    );
    wire step_p = pressed[0];
    wire home_p = pressed[1];
    wire [2:0] held = {step_p & home_p, home_p, step_p};

    // hold timers in ms: step, home, both; saturating
    logic [13:0] hold_reg [3];
    genvar g;
    for (g = 0; g < 3; g++) begin : g_hold
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) hold_reg[g] <= 14'h0000;
            else if (!held[g]) hold_reg[g] <= 14'h0000;
            else if (tick_reg && hold_reg[g] != 14'h3FFF)
                hold_reg[g] <= hold_reg[g] + 14'h0001;
        end
    end

    // one accept per closure, only while the other switch is open
    wire acc_pt   = tick_reg && hold_reg[0] == 14'(PRESS_ACC_MS - 1);
    wire acc_ph   = tick_reg && hold_reg[1] == 14'(PRESS_ACC_MS - 1);
    wire step_acc = acc_pt && step_p && !home_p;
    wire home_acc = acc_ph && home_p && !step_p;
    wire setup_hit = tick_reg && hold_reg[2] == 14'(SETUP_TICKS - 1);
    wire both_new  = held[2] && hold_reg[2] == 14'h0000;

    // mode machine
    mpac_mode_e mode_reg;
    mpac_mode_e mode_next;
    always_comb begin
        mode_next = mode_reg;
        unique case (mode_reg)
            MPAC_OPER:  if (held[2]) mode_next = MPAC_BOTH;
            MPAC_BOTH: begin
                if (setup_hit) mode_next = MPAC_SETUP;
                else if (!held[2]) mode_next = MPAC_OPER;
            end
            MPAC_SETUP: if (both_new) mode_next = MPAC_LEAVE;
            MPAC_LEAVE: if (!step_p && !home_p) mode_next = MPAC_OPER;
        endcase
    end
    wire dir_flip = mode_reg == MPAC_BOTH && mode_next == MPAC_OPER;
    wire oper     = mode_reg == MPAC_OPER;

    // registers and run state
    logic [6:0] count_reg;
    logic [6:0] offset_reg;
    logic [6:0] pos_reg;
    logic       dir_reg;
    logic       auto_reg;
    logic       run_reg;
    logic       fault_q;

    // bcd request decode and range check
    logic [7:0] bcd_q;
    logic       latch_q;
    wire        dig_ok   = bcd_in[7:4] < 4'hA && bcd_in[3:0] < 4'hA;
    wire [6:0]  bcd_bin  = 7'(bcd_in[7:4]) * 7'd10 + 7'(bcd_in[3:0]);
    wire [6:0]  lim_hi   = offset_reg + count_reg - 7'h01;
    wire        bcd_ok   = dig_ok && bcd_bin >= offset_reg
                           && bcd_bin <= lim_hi;
    wire        bcd_chg  = bcd_in != bcd_q;
    wire        bcd_trig = (data_latch && !latch_q)
                           || (auto_reg && bcd_chg);
    wire        can_move = oper && !run_reg;
    wire        step_go  = step_acc && can_move;
    wire        home_go  = home_acc && can_move;
    wire        bcd_go   = bcd_trig && bcd_ok && can_move && !step_go
                           && !home_go;
    wire [6:0]  step_pos = dir_reg ? (pos_reg <= 7'h01 ? count_reg
                                                       : pos_reg - 7'h01)
                                   : (pos_reg >= count_reg ? 7'h01
                                                           : pos_reg + 7'h01);
    wire [6:0]  cnt_lim  = POS_TOP - offset_reg;
    wire        set_inc  = mode_reg == MPAC_SETUP && step_acc
                           && count_reg < cnt_lim;
    wire        set_dec  = mode_reg == MPAC_SETUP && home_acc
                           && count_reg > COUNT_MIN;

    // apb decode: one wait state so read data comes from a flop
    logic        pready_reg;
    wire         acc     = psel && penable;
    wire         fin     = acc && pready_reg;
    wire         wr      = fin && pwrite;
    wire         hit_ctl = paddr == ADDR_CTRL;
    wire         hit_cfg = paddr == ADDR_CONFIG;
    wire         hit_sta = paddr == ADDR_STATUS;
    wire         hit_is  = paddr == ADDR_IRQ_STAT;
    wire         hit_im  = paddr == ADDR_IRQ_MASK;
    wire         mapped  = hit_ctl | hit_cfg | hit_sta | hit_is | hit_im;
    wire [6:0]   w_cnt   = pwdata[CFG_COUNT_LSB +: 7];
    wire [6:0]   w_off   = pwdata[CFG_OFFSET_LSB +: 7];
    wire         cfg_ok  = w_cnt >= COUNT_MIN && w_off >= OFFSET_RST
                           && 8'(w_cnt) + 8'(w_off) <= 8'(POS_TOP);
    wire         cfg_wr  = wr && hit_cfg && cfg_ok && oper;

    // interrupt events; set wins over the read clear
    logic [IRQ_W-1:0] istat_reg;
    logic [IRQ_W-1:0] imask_reg;
    wire  [IRQ_W-1:0] ev = {mode_next != mode_reg, fault_in && !fault_q,
                            run_reg && motor_done, bcd_go, home_go, step_go};
    wire  [IRQ_W-1:0] iclr = (fin && !pwrite && hit_is) ? istat_reg : '0;

    wire [31:0] rd_mux =
        hit_ctl ? 32'(auto_reg) << CTRL_AUTO_LATCH :
        hit_cfg ? (32'(count_reg) << CFG_COUNT_LSB)
                  | (32'(offset_reg) << CFG_OFFSET_LSB) :
        hit_sta ? (32'(pos_reg) << STAT_POS_LSB)
                  | (32'(mode_reg) << STAT_MODE_LSB)
                  | (32'(run_reg) << STAT_RUN) | (32'(dir_reg) << STAT_DIR)
                  | (32'(fault_in) << STAT_FAULT) :
        hit_is  ? 32'(istat_reg) :
        hit_im  ? 32'(imask_reg) : 32'h00000000;

    // bus slave flops
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= acc && !pready_reg;
            prdata_reg  <= (acc && !pready_reg) ? rd_mux : 32'h00000000;
            pslverr_reg <= acc && !pready_reg && !mapped;
        end
    end

    // software state and interrupt status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_reg  <= 1'b0;
            imask_reg <= '0;
            istat_reg <= '0;
        end else begin
            if (wr && hit_ctl) auto_reg <= pwdata[CTRL_AUTO_LATCH];
            if (wr && hit_im) imask_reg <= pwdata[IRQ_W-1:0];
            istat_reg <= (istat_reg & ~iclr) | ev;
        end
    end

    // mode, direction and configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg   <= MPAC_OPER;
            dir_reg    <= 1'b0;
            count_reg  <= COUNT_RST;
            offset_reg <= OFFSET_RST;
        end else begin
            mode_reg <= mode_next;
            if (dir_flip) dir_reg <= ~dir_reg;
            if (set_inc) count_reg <= count_reg + 7'h01;
            else if (set_dec) count_reg <= count_reg - 7'h01;
            else if (cfg_wr) count_reg <= w_cnt;
            if (cfg_wr) offset_reg <= w_off;
        end
    end

    // position and motion; a request while running is dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_reg <= 7'h01;
            run_reg <= 1'b0;
            bcd_q   <= 8'h00;
            latch_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            bcd_q   <= bcd_in;
            latch_q <= data_latch;
            fault_q <= fault_in;
            if (step_go) pos_reg <= step_pos;
            else if (home_go) pos_reg <= 7'h01;
            else if (bcd_go) pos_reg <= bcd_bin - offset_reg + 7'h01;
            if (step_go || home_go || bcd_go) run_reg <= 1'b1;
            else if (motor_done) run_reg <= 1'b0;
        end
    end

    // blink timer for setup display
    logic [7:0] blink_reg;
    logic       flash_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blink_reg <= 8'h00;
            flash_reg <= 1'b0;
        end else if (tick_reg) begin
            blink_reg <= (blink_reg == 8'(FLASH_MS - 1)) ? 8'h00
                                                         : blink_reg + 8'h01;
            if (blink_reg == 8'(FLASH_MS - 1)) flash_reg <= ~flash_reg;
        end
    end

    // registered outputs
    logic [7:0] bcd_out_reg;
    logic [7:0] disp_reg;
    logic       blank_reg;
    logic       dfault_reg;
    logic       led_fwd_reg;
    logic       irq_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcd_out_reg <= 8'h01;
            disp_reg    <= 8'h01;
            blank_reg   <= 1'b0;
            dfault_reg  <= 1'b0;
            led_fwd_reg <= 1'b1;
            irq_reg     <= 1'b0;
        end else begin
            bcd_out_reg <= to_bcd(pos_reg);
            disp_reg    <= to_bcd(mode_reg == MPAC_SETUP ? count_reg
                                                         : pos_reg);
            blank_reg   <= mode_reg == MPAC_SETUP && flash_reg;
            dfault_reg  <= fault_in;
            led_fwd_reg <= dir_flip ? dir_reg : !dir_reg;
            irq_reg     <= |(istat_reg & imask_reg);
        end
    end

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign motor_run   = run_reg;
    assign dir_out     = dir_reg;
    assign error_out   = dfault_reg;
    assign bcd_out     = bcd_out_reg;
    assign disp_value  = disp_reg;
    assign disp_blank  = blank_reg;
    assign disp_fault  = dfault_reg;
    assign led_dir_fwd = led_fwd_reg;
    assign led_dir_rev = dir_reg;
    assign irq         = irq_reg;

    // checks
    a_step_moves: assert property (step_go |=> run_reg
        && pos_reg == $past(step_pos)) else $error("step not taken");
    a_home_pos1: assert property (home_go |=> pos_reg == 7'h01
        ##1 bcd_out_reg == 8'h01) else $error("home not position 1");
    a_dir_flip: assert property (dir_flip |=> dir_reg != $past(dir_reg)
        && led_dir_fwd != led_dir_rev) else $error("direction not reversed");
    a_setup_entry: assert property (mode_reg == MPAC_BOTH
        ##1 mode_reg == MPAC_SETUP |-> held[2]
        && hold_reg[2] == 14'(SETUP_TICKS)) else $error("setup early");
    a_setup_inc: assert property (set_inc |=>
        count_reg == $past(count_reg) + 7'h01) else $error("no increment");
    a_setup_leave: assert property (mode_reg == MPAC_SETUP && both_new
        |=> mode_reg == MPAC_LEAVE ##1 !blank_reg) else $error("no exit");
    a_fault_show: assert property (fault_in |=> dfault_reg
        && error_out) else $error("fault not shown");
    a_bcd_range: assert property (bcd_go |-> bcd_bin >= offset_reg
        && bcd_bin <= lim_hi) else $error("bcd out of range");
    a_auto_latch: assert property (auto_reg && bcd_chg && bcd_ok
        && can_move |=> run_reg) else $error("auto latch ignored");
    a_run_done: assert property (run_reg && motor_done && !step_go
        && !home_go && !bcd_go |=> !run_reg) else $error("run stuck");
    a_bcd_out: assert property ($stable(pos_reg) [*2]
        |-> bcd_out_reg == to_bcd(pos_reg)) else $error("bcd out stale");
    c_step: cover property (step_go ##[1:300] motor_done);
    c_flip: cover property (dir_flip);
    c_setup: cover property (mode_reg == MPAC_SETUP ##1 set_inc);
    c_bcd: cover property (bcd_go && auto_reg);
endmodule // mpac_top

// File: verification/mpac_contact_model.sv
// contact closure and motor side model facing the actuator front end
module mpac_contact_model #(
    parameter int TICK_CYCLES = 4
) (
    input  wire logic pclk,
    input  wire logic motor_run,
    output logic      step_in_n,
    output logic      home_in_n,
    output logic      motor_done
);
    timeunit 1ns;
    timeprecision 100ps;

    int done_delay = 3;
    int wait_cnt   = 0;

    // released contacts sit at the pull-up level
    initial begin
        step_in_n  = 1'b1;
        home_in_n  = 1'b1;
        motor_done = 1'b0;
    end

    // momentary closure only, never a driven level; ms kept under 5 s
    task automatic press(input logic s, input logic h, input int ms);
        @(posedge pclk);
        step_in_n <= ~s;
        home_in_n <= ~h;
        repeat (ms * TICK_CYCLES) @(posedge pclk);
        step_in_n <= 1'b1;
        home_in_n <= 1'b1;
        repeat (20 * TICK_CYCLES) @(posedge pclk);
    endtask

    // motor ends a move after done_delay cycles; slow values stress refusal
    always @(posedge pclk) begin
        motor_done <= motor_run && !motor_done && wait_cnt >= done_delay;
        if (motor_run && !motor_done && wait_cnt < done_delay) begin
            wait_cnt <= wait_cnt + 1;
        end else begin
            wait_cnt <= 0;
        end
    end
endmodule // mpac_contact_model

// File: verification/multiposition_actuator_control_tb_top.sv
// self-checking bench of the actuator front end
module multiposition_actuator_control_tb_top;
    import mpac_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, step_in_n, home_in_n, motor_done;
    logic        data_latch = 1'b0;
    logic [7:0]  bcd_in = 8'h00;
    logic        fault_in = 1'b0;
    logic        motor_run, dir_out, error_out, disp_blank, disp_fault;
    logic        led_dir_fwd, led_dir_rev, irq, run_q, e, seen;
    logic [7:0]  bcd_out, disp_value, cur;
    logic [31:0] d;
    int          n_errors = 0;
    int          checks_done = 0;
    int          run_starts = 0;
    int          v, n0;
    integer      seed = 32'hE07DAE27;

    // short ms tick and setup hold keep the run brief
    mpac_top #(.TICK_CYCLES(4), .SETUP_TICKS(100)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .step_in_n(step_in_n),
        .home_in_n(home_in_n), .data_latch(data_latch), .bcd_in(bcd_in),
        .motor_done(motor_done), .fault_in(fault_in),
        .motor_run(motor_run), .dir_out(dir_out), .error_out(error_out),
        .bcd_out(bcd_out), .disp_value(disp_value), .disp_blank(disp_blank),
        .disp_fault(disp_fault), .led_dir_fwd(led_dir_fwd),
        .led_dir_rev(led_dir_rev), .irq(irq));

    mpac_contact_model #(.TICK_CYCLES(4)) partner_u (
        .pclk(pclk), .motor_run(motor_run), .step_in_n(step_in_n),
        .home_in_n(home_in_n), .motor_done(motor_done));

    always #12.5 pclk = ~pclk;

    // count move starts so a doubled or lost accept shows up
    always @(posedge pclk) begin
        run_q <= motor_run;
        if (motor_run === 1'b1 && run_q === 1'b0) run_starts <= run_starts + 1;
    end

    function automatic logic [7:0] to_bcd(input int x);
        return 8'(((x / 10) << 4) | (x % 10));
    endfunction

    task automatic check(input string what, input logic [31:0] got,
                         input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; waits for pready under a bound, no fixed latency
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) check("pready", 32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        logic [31:0] r;
        logic        x;
        apb(1'b0, a, 32'h0, r, x);
        check(what, r, exp);
    endtask

    task automatic bcd_req(input logic [7:0] b, input logic latch);
        @(posedge pclk);
        bcd_in <= b;
        data_latch <= latch;
        @(posedge pclk);
        data_latch <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask

    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog well beyond the expected five and a half thousand cycles
    initial begin
        #(40000 * 25);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("reset outs", 32'({bcd_out, disp_value, led_dir_fwd,
              led_dir_rev, motor_run, irq}), 32'h01018);
        rd_chk(ADDR_STATUS, 32'h1, "status");
        rd_chk(ADDR_CONFIG, 32'h10A, "config");
        apb(1'b0, 8'h20, 32'h0, d, e);
        check("slverr", 32'(e), 32'h1);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1, d, e);
        partner_u.press(1'b1, 1'b0, 50);
        check("step pos", 32'(bcd_out), 32'h02);
        check("step runs", run_starts, 1);
        check("irq set", 32'(irq), 32'h1);
        rd_chk(ADDR_IRQ_STAT, 32'h9, "irq stat");
        repeat (3) @(posedge pclk);
        check("irq clear", 32'(irq), 32'h0);
        partner_u.press(1'b0, 1'b1, 50);
        check("home pos", 32'(bcd_out), 32'h01);
        check("irq masked", 32'(irq), 32'h0);
        partner_u.press(1'b1, 1'b1, 50);
        check("dir leds", 32'({dir_out, led_dir_fwd, led_dir_rev}),
              32'h5);
        check("both no move", run_starts, 2);
        partner_u.press(1'b1, 1'b0, 50);
        check("reverse step", 32'(bcd_out), 32'h10);
        partner_u.press(1'b1, 1'b1, 50);
        // slow motor: a second step during the move must be dropped
        partner_u.done_delay = 400;
        n0 = run_starts;
        partner_u.press(1'b1, 1'b0, 50);
        partner_u.press(1'b1, 1'b0, 50);
        repeat (300) @(posedge pclk);
        check("busy refuse", 32'(bcd_out), 32'h01);
        check("busy runs", run_starts, n0 + 1);
        partner_u.done_delay = 3;
        for (int i = 0; i < 4; i++) begin
            v = 1 + ($unsigned($random(seed)) % 10);
            bcd_req(to_bcd(v), 1'b1);
            check("bcd move", 32'(bcd_out), 32'(to_bcd(v)));
        end
        cur = bcd_out;
        bcd_req(8'h11, 1'b1);
        check("bcd above", 32'(bcd_out), 32'(cur));
        bcd_req(8'h0A, 1'b1);
        check("bcd digit", 32'(bcd_out), 32'(cur));
        apb(1'b1, ADDR_CONFIG, 32'h0305, d, e);
        bcd_req(8'h07, 1'b1);
        check("offset top", 32'(bcd_out), 32'h05);
        bcd_req(8'h08, 1'b1);
        check("offset over", 32'(bcd_out), 32'h05);
        bcd_req(8'h02, 1'b1);
        check("offset under", 32'(bcd_out), 32'h05);
        apb(1'b1, ADDR_CONFIG, 32'h010A, d, e);
        bcd_req(8'h06, 1'b0);
        check("no auto", 32'(bcd_out), 32'h05);
        apb(1'b1, ADDR_CTRL, 32'h1, d, e);
        bcd_req(8'h04, 1'b0);
        check("auto latch", 32'(bcd_out), 32'h04);
        apb(1'b1, ADDR_CTRL, 32'h0, d, e);
        fault_in <= 1'b1;
        repeat (3) @(posedge pclk);
        check("fault on", 32'({error_out, disp_fault}), 32'h3);
        fault_in <= 1'b0;
        repeat (3) @(posedge pclk);
        check("fault off", 32'({error_out, disp_fault}), 32'h0);
        partner_u.press(1'b1, 1'b1, 120);
        rd_chk(ADDR_STATUS, 32'h304, "setup mode");
        check("setup disp", 32'(disp_value), 32'h10);
        seen = 1'b0;
        repeat (1200) begin
            @(posedge pclk);
            if (disp_blank === 1'b1) seen = 1'b1;
        end
        check("flash", 32'(seen), 32'h1);
        partner_u.press(1'b1, 1'b0, 50);
        check("count up", 32'(disp_value), 32'h11);
        partner_u.press(1'b0, 1'b1, 50);
        partner_u.press(1'b0, 1'b1, 50);
        check("count down", 32'(disp_value), 32'h09);
        partner_u.press(1'b1, 1'b1, 50);
        rd_chk(ADDR_STATUS, 32'h4, "oper mode");
        check("no flash", 32'({disp_blank, disp_value}), 32'h04);
        rd_chk(ADDR_CONFIG, 32'h109, "new count");
        finish_test();
    end
endmodule // multiposition_actuator_control_tb_top
